// *** verilog/iepr_map.vh ***
// Register map, field positions and reset values of the enable and priority registers
`ifndef IEPR_MAP_VH
`define IEPR_MAP_VH
// ----------------------------------------
// Word offsets (byte addresses)
// ----------------------------------------
`define IEPR_OFS_ENABLE 5'h00
`define IEPR_OFS_PRIO0 5'h04
`define IEPR_OFS_PRIO1 5'h08
`define IEPR_OFS_PRIO2 5'h0C
`define IEPR_OFS_PRIO3 5'h10
`define IEPR_ADDR_W 5
`define IEPR_A_ENABLE 5'h00
`define IEPR_A_PRIO0 5'h04
`define IEPR_A_PRIO1 5'h08
`define IEPR_A_PRIO2 5'h0C
`define IEPR_A_PRIO3 5'h10
// ----------------------------------------
// Writable bit masks
// ----------------------------------------
`define IEPR_MASK_ENABLE 16'h3FFE
`define IEPR_MASK_PRIO0 16'h7777
`define IEPR_MASK_PRIO1 16'h7770
`define IEPR_MASK_PRIO2 16'h7777
`define IEPR_MASK_PRIO3 16'h0077
// ----------------------------------------
// Reset values
// ----------------------------------------
`define IEPR_RST_ENABLE 16'h0000
`define IEPR_RST_PRIO0 16'h4444
`define IEPR_RST_PRIO1 16'h4440
`define IEPR_RST_PRIO2 16'h4444
`define IEPR_RST_PRIO3 16'h0044
// ----------------------------------------
// Enable bit positions
// ----------------------------------------
`define IEPR_BIT_CAPTURE9 13
`define IEPR_BIT_COMPARE9 12
`define IEPR_BIT_SPI_C_EVENT 11
`define IEPR_BIT_SPI_C_FAULT 10
`define IEPR_BIT_UART_D_TX 9
`define IEPR_BIT_UART_D_RX 8
`define IEPR_BIT_UART_D_ERR 7
`define IEPR_BIT_USB 6
`define IEPR_BIT_I2C_C_MASTER 5
`define IEPR_BIT_I2C_C_SLAVE 4
`define IEPR_BIT_UART_C_TX 3
`define IEPR_BIT_UART_C_RX 2
`define IEPR_BIT_UART_C_ERR 1
// ----------------------------------------
// Priority field low bit positions
// ----------------------------------------
`define IEPR_FLD_HI 12
`define IEPR_FLD_MH 8
`define IEPR_FLD_ML 4
`define IEPR_FLD_LO 0
`define IEPR_PRIO_OFF 3'h0
`endif

// *** verilog/iepr_gate.v ***
// Request gate for one interrupt source
`timescale 1ns/1ns
`default_nettype none
module iepr_gate (
  input wire flag,
  input wire enable,
  input wire [2:0] prio,
  output wire req,
  output wire [2:0] req_prio
);
  // Zero priority kills the source whatever the enable says
  assign req = flag & enable & (prio != 3'h0);
  // Level follows the field code directly, 1 lowest to 7 highest
  assign req_prio = req ? prio : 3'h0;
endmodule
`default_nettype wire

// *** verilog/iepr_regs.v ***
// Interrupt enable and priority registers with Avalon-MM slave and request gating
//
// Notes on behaviour
// - An enable bit of one passes its source's request and zero blocks it.
// - A priority field is the level itself, with all ones giving level seven, the highest.
// - Field code one gives level one, the lowest live level, and codes between map linearly.
// - A priority field of zero disables its source whatever the enable bit holds.
// - Unimplemented bits read as zero and ignore writes.
// - Reset clears every enable bit.
// - Reset loads every priority field with four.
// - Enable bits 13 to 1 cover capture 9, compare 9, SPI C event and fault, UART D tx rx err, USB, I2C C master and slave, UART C tx rx err; bits 15, 14 and 0 are empty.
// - Priority register zero holds timer A, compare A, capture A and external irq zero from top field down.
// - Priority register one holds timer B, compare B and capture B, its low four bits empty.
// - Priority register two holds UART A rx, SPI A event, SPI A fault and timer C from top field down.
// - Priority register three holds only ADC done in bits 6-4 and UART A tx in bits 2-0.
`timescale 1ns/1ns
`default_nettype none
`include "iepr_map.vh"
module iepr_regs #(
  parameter NUM_ENABLE = 13,
  parameter NUM_PRIO = 14
) (
  input wire clk,
  input wire reset_n,
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  output reg [1:0] avs_response,
  input wire [NUM_ENABLE-1:0] enable_src_flag,
  output wire [NUM_ENABLE-1:0] enable_src_req,
  output wire [NUM_ENABLE-1:0] enable_src_en,
  input wire [NUM_PRIO-1:0] prio_src_flag,
  output wire [NUM_PRIO-1:0] prio_src_req,
  output wire [3*NUM_PRIO-1:0] prio_src_level,
  output wire capture9_irq_en,
  output wire compare9_irq_en,
  output wire spi_c_event_irq_en,
  output wire spi_c_fault_irq_en,
  output wire uart_d_tx_irq_en,
  output wire uart_d_rx_irq_en,
  output wire uart_d_err_irq_en,
  output wire usb_irq_en,
  output wire i2c_c_master_irq_en,
  output wire i2c_c_slave_irq_en,
  output wire uart_c_tx_irq_en,
  output wire uart_c_rx_irq_en,
  output wire uart_c_err_irq_en,
  output wire [2:0] timer_a_prio,
  output wire [2:0] compare_a_prio,
  output wire [2:0] capture_a_prio,
  output wire [2:0] ext_irq_zero_prio,
  output wire [2:0] timer_b_prio,
  output wire [2:0] compare_b_prio,
  output wire [2:0] capture_b_prio,
  output wire [2:0] uart_a_rx_prio,
  output wire [2:0] spi_a_event_prio,
  output wire [2:0] spi_a_fault_prio,
  output wire [2:0] timer_c_prio,
  output wire [2:0] adc_done_prio,
  output wire [2:0] uart_a_tx_prio
);
  // ----------------------------------------
  // Bus state
  // ----------------------------------------
  // One wait cycle per access keeps read data registered
  localparam ST_IDLE = 2'b01;
  localparam ST_DONE = 2'b10;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [15:0] source_enable_five_reg;
  reg [15:0] source_priority_zero_reg;
  reg [15:0] source_priority_one_reg;
  reg [15:0] source_priority_two_reg;
  reg [15:0] source_priority_three_reg;
  reg [15:0] wr_mask;
  reg [15:0] rd_word;
  reg hit;
  wire req_any;
  wire [15:0] lane_mask;
  wire [15:0] wdata;

  assign req_any = avs_read | avs_write;
  assign lane_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wdata = avs_writedata[15:0];
  // Request stalls in idle and is released in the done cycle
  assign avs_waitrequest = req_any & (state_reg != ST_DONE);

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (req_any) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  always @* begin
    hit = 1'b1;
    wr_mask = 16'h0000;
    rd_word = 16'h0000;
    case (avs_address)
      `IEPR_A_ENABLE: begin
        wr_mask = `IEPR_MASK_ENABLE;
        rd_word = source_enable_five_reg;
      end
      `IEPR_A_PRIO0: begin
        wr_mask = `IEPR_MASK_PRIO0;
        rd_word = source_priority_zero_reg;
      end
      `IEPR_A_PRIO1: begin
        wr_mask = `IEPR_MASK_PRIO1;
        rd_word = source_priority_one_reg;
      end
      `IEPR_A_PRIO2: begin
        wr_mask = `IEPR_MASK_PRIO2;
        rd_word = source_priority_two_reg;
      end
      `IEPR_A_PRIO3: begin
        wr_mask = `IEPR_MASK_PRIO3;
        rd_word = source_priority_three_reg;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  wire do_write;
  wire [15:0] wsel;
  // Write lands at the edge where the master sees waitrequest low, never earlier
  assign do_write = avs_write & (state_reg == ST_DONE);
  // Only implemented bits in enabled lanes take the write
  assign wsel = wr_mask & lane_mask;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      avs_readdata <= 32'h0000_0000;
      avs_response <= 2'b00;
      source_enable_five_reg <= `IEPR_RST_ENABLE;
      source_priority_zero_reg <= `IEPR_RST_PRIO0;
      source_priority_one_reg <= `IEPR_RST_PRIO1;
      source_priority_two_reg <= `IEPR_RST_PRIO2;
      source_priority_three_reg <= `IEPR_RST_PRIO3;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_IDLE && req_any) begin
        avs_response <= hit ? 2'b00 : 2'b11;
        // Unimplemented positions stay zero because stored bits are masked
        avs_readdata <= avs_read ? {16'h0000, rd_word} : 32'h0000_0000;
      end
      if (do_write && avs_address == `IEPR_A_ENABLE) begin
        source_enable_five_reg <= (source_enable_five_reg & ~wsel) | (wdata & wsel);
      end
      if (do_write && avs_address == `IEPR_A_PRIO0) begin
        source_priority_zero_reg <= (source_priority_zero_reg & ~wsel) | (wdata & wsel);
      end
      if (do_write && avs_address == `IEPR_A_PRIO1) begin
        source_priority_one_reg <= (source_priority_one_reg & ~wsel) | (wdata & wsel);
      end
      if (do_write && avs_address == `IEPR_A_PRIO2) begin
        source_priority_two_reg <= (source_priority_two_reg & ~wsel) | (wdata & wsel);
      end
      if (do_write && avs_address == `IEPR_A_PRIO3) begin
        source_priority_three_reg <= (source_priority_three_reg & ~wsel) | (wdata & wsel);
      end
    end
  end

  // ----------------------------------------
  // Field outputs
  // ----------------------------------------
  wire [15:0] en;
  assign en = source_enable_five_reg;
  assign capture9_irq_en = en[`IEPR_BIT_CAPTURE9];
  assign compare9_irq_en = en[`IEPR_BIT_COMPARE9];
  assign spi_c_event_irq_en = en[`IEPR_BIT_SPI_C_EVENT];
  assign spi_c_fault_irq_en = en[`IEPR_BIT_SPI_C_FAULT];
  assign uart_d_tx_irq_en = en[`IEPR_BIT_UART_D_TX];
  assign uart_d_rx_irq_en = en[`IEPR_BIT_UART_D_RX];
  assign uart_d_err_irq_en = en[`IEPR_BIT_UART_D_ERR];
  assign usb_irq_en = en[`IEPR_BIT_USB];
  assign i2c_c_master_irq_en = en[`IEPR_BIT_I2C_C_MASTER];
  assign i2c_c_slave_irq_en = en[`IEPR_BIT_I2C_C_SLAVE];
  assign uart_c_tx_irq_en = en[`IEPR_BIT_UART_C_TX];
  assign uart_c_rx_irq_en = en[`IEPR_BIT_UART_C_RX];
  assign uart_c_err_irq_en = en[`IEPR_BIT_UART_C_ERR];
  // Enable vector index 0 is bit 1, upward to bit 13
  assign enable_src_en = en[NUM_ENABLE:1];
  // Their priorities sit in registers outside this slice, so only flag and enable gate here
  assign enable_src_req = enable_src_flag & enable_src_en;

  assign timer_a_prio = source_priority_zero_reg[`IEPR_FLD_HI+2:`IEPR_FLD_HI];
  assign compare_a_prio = source_priority_zero_reg[`IEPR_FLD_MH+2:`IEPR_FLD_MH];
  assign capture_a_prio = source_priority_zero_reg[`IEPR_FLD_ML+2:`IEPR_FLD_ML];
  assign ext_irq_zero_prio = source_priority_zero_reg[`IEPR_FLD_LO+2:`IEPR_FLD_LO];
  assign timer_b_prio = source_priority_one_reg[`IEPR_FLD_HI+2:`IEPR_FLD_HI];
  assign compare_b_prio = source_priority_one_reg[`IEPR_FLD_MH+2:`IEPR_FLD_MH];
  assign capture_b_prio = source_priority_one_reg[`IEPR_FLD_ML+2:`IEPR_FLD_ML];
  assign uart_a_rx_prio = source_priority_two_reg[`IEPR_FLD_HI+2:`IEPR_FLD_HI];
  assign spi_a_event_prio = source_priority_two_reg[`IEPR_FLD_MH+2:`IEPR_FLD_MH];
  assign spi_a_fault_prio = source_priority_two_reg[`IEPR_FLD_ML+2:`IEPR_FLD_ML];
  assign timer_c_prio = source_priority_two_reg[`IEPR_FLD_LO+2:`IEPR_FLD_LO];
  assign adc_done_prio = source_priority_three_reg[`IEPR_FLD_ML+2:`IEPR_FLD_ML];
  assign uart_a_tx_prio = source_priority_three_reg[`IEPR_FLD_LO+2:`IEPR_FLD_LO];

  // ----------------------------------------
  // Request gating per prioritised source
  // ----------------------------------------
  // Their enable bits live elsewhere; here the enable input is tied high
  wire [3*NUM_PRIO-1:0] prio_vec;
  assign prio_vec = {3'h0, uart_a_tx_prio, adc_done_prio, timer_c_prio, spi_a_fault_prio,
    spi_a_event_prio, uart_a_rx_prio, capture_b_prio, compare_b_prio, timer_b_prio,
    ext_irq_zero_prio, capture_a_prio, compare_a_prio, timer_a_prio};

  genvar g;
  generate
    for (g = 0; g < NUM_PRIO - 1; g = g + 1) begin : g_src
      iepr_gate u_gate (
        .flag(prio_src_flag[g]),
        .enable(1'b1),
        .prio(prio_vec[3*g+2:3*g]),
        .req(prio_src_req[g]),
        .req_prio(prio_src_level[3*g+2:3*g])
      );
    end
  endgenerate
  // Spare last slot stays idle
  assign prio_src_req[NUM_PRIO-1] = 1'b0;
  assign prio_src_level[3*NUM_PRIO-1:3*NUM_PRIO-3] = 3'h0;
endmodule
`default_nettype wire

// *** verif/iepr_regs_sva.sv ***
// Checker for the enable and priority register block
`timescale 1ns/1ns
`default_nettype none
module iepr_regs_sva #(
  parameter NUM_ENABLE = 13,
  parameter NUM_PRIO = 14
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  input wire logic [NUM_ENABLE-1:0] enable_src_flag,
  input wire logic [NUM_ENABLE-1:0] enable_src_req,
  input wire logic [NUM_ENABLE-1:0] enable_src_en,
  input wire logic [NUM_PRIO-1:0] prio_src_flag,
  input wire logic [NUM_PRIO-1:0] prio_src_req,
  input wire logic [3*NUM_PRIO-1:0] prio_src_level,
  input wire logic capture9_irq_en,
  input wire logic uart_c_err_irq_en,
  input wire logic [2:0] timer_a_prio,
  input wire logic [2:0] uart_a_tx_prio
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_rd_done;
    avs_read && !avs_waitrequest;
  endsequence
  sequence s_bad_rd;
    s_rd_done ##0 (avs_address > 5'h10);
  endsequence
  chk_en_gate: assert property (enable_src_req == (enable_src_flag & enable_src_en))
    else $error("enable gate wrong");
  chk_prio_gate: assert property (prio_src_req[0] == (prio_src_flag[0] && timer_a_prio != 3'h0))
    else $error("priority gate wrong");
  chk_level_pass: assert property (prio_src_level[2:0] == (prio_src_req[0] ? timer_a_prio : 3'h0))
    else $error("level not passed");
  chk_tx_gate: assert property (prio_src_req[12] == (prio_src_flag[12] && uart_a_tx_prio != 3'h0))
    else $error("tx gate wrong");
  chk_rd_upper: assert property (s_rd_done |-> avs_readdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  chk_unmapped_rd: assert property (s_bad_rd |-> avs_readdata == 32'h0000_0000 && avs_response == 2'h3)
    else $error("unmapped read wrong");
  chk_en_map: assert property (capture9_irq_en == enable_src_en[12] && uart_c_err_irq_en == enable_src_en[0])
    else $error("enable map wrong");
  chk_reset_en: assert property ($rose(reset_n) |-> enable_src_en == '0)
    else $error("enable not cleared");
  chk_reset_prio: assert property ($rose(reset_n) |-> timer_a_prio == 3'h4 && uart_a_tx_prio == 3'h4)
    else $error("priority not four");
endmodule
`default_nettype wire

// *** verif/iepr_arb_model.sv ***
// Arbitration model picking the highest level among pending sources
`timescale 1ns/1ns
`default_nettype none
module iepr_arb_model (
  input wire logic [13:0] req,
  input wire logic [41:0] level,
  output logic [2:0] best
);
  always_comb begin
    best = 3'h0;
    for (int i = 0; i < 14; i++) begin
      if (req[i] && level[3*i +: 3] > best) begin
        best = level[3*i +: 3];
      end
    end
  end
endmodule
`default_nettype wire

// *** verif/tb_irq_enable_priority_regs.sv ***
// Self-checking bench for the enable and priority register block
`timescale 1ns/1ns
`default_nettype none
module tb_irq_enable_priority_regs;
  // ----------------------------------------
  // Stimulus and checks
  // ----------------------------------------
  logic clk, reset_n, avs_read, avs_write, capture9_irq_en, uart_c_err_irq_en;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable;
  logic avs_waitrequest;
  logic [1:0] avs_response, rsp;
  logic [12:0] enable_src_flag, enable_src_req, enable_src_en;
  logic [13:0] prio_src_flag, prio_src_req;
  logic [41:0] prio_src_level;
  logic [2:0] timer_a_prio, compare_a_prio, capture_a_prio, ext_irq_zero_prio, uart_a_tx_prio, best;
  int num_errors = 0;
  int compares = 0;
  logic [4:0] adr_t [5] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10};
  logic [15:0] rst_t [5] = '{16'h0000, 16'h4444, 16'h4440, 16'h4444, 16'h0044};
  logic [15:0] msk_t [5] = '{16'h3ffe, 16'h7777, 16'h7770, 16'h7777, 16'h0077};
  iepr_regs dut (.clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response, .enable_src_flag,
    .enable_src_req, .enable_src_en, .prio_src_flag, .prio_src_req, .prio_src_level,
    .capture9_irq_en, .compare9_irq_en(), .spi_c_event_irq_en(), .spi_c_fault_irq_en(),
    .uart_d_tx_irq_en(), .uart_d_rx_irq_en(), .uart_d_err_irq_en(), .usb_irq_en(),
    .i2c_c_master_irq_en(), .i2c_c_slave_irq_en(), .uart_c_tx_irq_en(), .uart_c_rx_irq_en(),
    .uart_c_err_irq_en, .timer_a_prio, .compare_a_prio, .capture_a_prio, .ext_irq_zero_prio,
    .timer_b_prio(), .compare_b_prio(), .capture_b_prio(), .uart_a_rx_prio(),
    .spi_a_event_prio(), .spi_a_fault_prio(), .timer_c_prio(), .adc_done_prio(), .uart_a_tx_prio);
  iepr_arb_model partner (.req(prio_src_req), .level(prio_src_level), .best(best));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    // Only the watchdog ends a wait that never sees waitrequest low
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    rsp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic t_reset_vals;
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, adr_t[i], 16'h0000);
      check(q, {16'h0000, rst_t[i]});
    end
  endtask
  task automatic t_masks;
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, adr_t[i], 16'hffff);
      bus(1'b0, adr_t[i], 16'h0000);
      check(q, {16'h0000, msk_t[i]});
      bus(1'b1, adr_t[i], 16'h0000);
    end
  endtask
  task automatic t_enable_walk;
    enable_src_flag <= 13'h1fff;
    for (int i = 1; i < 14; i++) begin
      bus(1'b1, 5'h00, 16'h0001 << i);
      @(negedge clk);
      check(enable_src_en, 13'h0001 << (i - 1));
      check(enable_src_req, 13'h0001 << (i - 1));
      check(capture9_irq_en, i == 13);
    end
    @(posedge clk);
    enable_src_flag <= 13'h0000;
    @(negedge clk);
    check(enable_src_req, 13'h0000);
  endtask
  task automatic t_prio_codes;
    logic [2:0] c;
    logic [2:0] nc;
    prio_src_flag <= 14'h3fff;
    for (int i = 0; i < 8; i++) begin
      c = i;
      nc = ~c;
      bus(1'b1, 5'h04, {1'b0, c, 1'b0, ~c, 1'b0, c, 1'b0, ~c});
      @(negedge clk);
      check({timer_a_prio, compare_a_prio, capture_a_prio, ext_irq_zero_prio}, {c, ~c, c, ~c});
      check(prio_src_req[1:0], {~c != 3'h0, c != 3'h0});
      check(prio_src_level[5:0], {~c, c});
      check(best, (c > nc) ? c : nc);
    end
  endtask
  task automatic t_prio_fields;
    bus(1'b1, 5'h08, 16'h1234);
    bus(1'b1, 5'h0c, 16'h1234);
    bus(1'b1, 5'h10, 16'h1234);
    @(negedge clk);
    check(prio_src_level[38:12], 27'h471_a2d1);
    check(prio_src_req[13], 1'b0);
  endtask
  task automatic t_unmapped;
    bus(1'b1, 5'h14, 16'hffff);
    check(rsp, 2'h3);
    bus(1'b0, 5'h14, 16'h0000);
    check(rsp, 2'h3);
    check(q, 32'h0000_0000);
    // The refused write must leave the enable word from the walk alone
    bus(1'b0, 5'h00, 16'h0000);
    check(q, 32'h0000_2000);
    // Upper lane off: only the low byte of the enable word takes the write
    avs_byteenable <= 4'h1;
    bus(1'b1, 5'h00, 16'hffff);
    avs_byteenable <= 4'hf;
    bus(1'b0, 5'h00, 16'h0000);
    check(q, 32'h0000_20fe);
  endtask
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #20000;
    num_errors++;
    give_verdict();
  end
  initial begin
    reset_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hf;
    enable_src_flag = 13'h0000;
    prio_src_flag = 14'h0000;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    t_reset_vals();
    t_masks();
    t_enable_walk();
    t_prio_codes();
    t_prio_fields();
    t_unmapped();
    // A second reset in mid-run must bring back every default
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    t_reset_vals();
    give_verdict();
  end
endmodule
bind iepr_regs iepr_regs_sva #(.NUM_ENABLE(NUM_ENABLE), .NUM_PRIO(NUM_PRIO)) chk (.clk, .reset_n,
  .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .avs_response,
  .enable_src_flag, .enable_src_req, .enable_src_en, .prio_src_flag, .prio_src_req,
  .prio_src_level, .capture9_irq_en, .uart_c_err_irq_en, .timer_a_prio, .uart_a_tx_prio);
`default_nettype wire
